// *** logic/sss_top.v ***
`timescale 1ns/1ps
`include "sss_consts.vh"
module sss_top #(
	parameter [15:0] OC_FILT_CYC = `SSS_OC_FILT_CYC,
	parameter [15:0] FAULT_CYC   = `SSS_FAULT_CYC,
	parameter [15:0] RST_CYC     = `SSS_RST_CYC
) (
	input  wire        aclk,          // system clock, 100 MHz
	input  wire        aresetn,       // synchronous reset, active low
	input  wire        ce,            // clock enable, freezes all state
	input  wire [7:0]  awaddr,        // write address
	input  wire        awvalid,       // write address valid
	output reg         awready,       // write address ready
	input  wire [31:0] wdata,         // write data
	input  wire [3:0]  wstrb,         // write byte strobes
	input  wire        wvalid,        // write data valid
	output reg         wready,        // write data ready
	output reg  [1:0]  bresp,         // write response
	output reg         bvalid,        // write response valid
	input  wire        bready,        // write response ready
	input  wire [7:0]  araddr,        // read address
	input  wire        arvalid,       // read address valid
	output reg         arready,       // read address ready
	output reg  [31:0] rdata,         // read data
	output reg  [1:0]  rresp,         // read response
	output reg         rvalid,        // read data valid
	input  wire        rready,        // read data ready
	input  wire        rail_lockout,  // internal rail below lockout
	input  wire        enable_cmp,    // enable input above threshold
	input  wire        seq_ctl,       // sequence control input
	input  wire [3:0]  dly_cross,     // delay inputs past threshold, ch 2..5
	input  wire        rst_mon_ok,    // reset monitor above trip level
	input  wire [5:0]  uv_cmp,        // output below 90 percent, per reg
	input  wire        oc_cmp,        // overcurrent comparator
	input  wire        therm_cmp,     // over-temperature sensor
	output reg  [5:0]  reg_en,        // enables: step-down, logic, ch 2..5
	output wire [35:0] ref_code,      // six 6-bit reference codes
	output reg         dly_charge,    // delay charge sources on
	output reg         dly_discharge, // delay discharge switches closed
	output reg         seq_blk_en,    // sequencing block enabled
	output reg         rst_pin_o,     // reset pin level, always low
	output reg         rst_pin_oe_n,  // reset pin enable, low drives low
	output reg         rail_off       // shut down internal rail
);

	// ----------------------------------------------------------------
	// input synchronisation
	// ----------------------------------------------------------------
	wire [15:0] raw_in;
	wire [15:0] syn;
	wire        lock_s;
	wire        en_s;
	wire        seq_s;
	wire [3:0]  dly_s;
	wire        mon_s;
	wire [5:0]  uv_s;
	wire        oc_s;
	wire        th_s;

	assign raw_in = {therm_cmp, oc_cmp, uv_cmp, rst_mon_ok, dly_cross,
	                 seq_ctl, enable_cmp, rail_lockout};
	assign lock_s = syn[0];
	assign en_s   = syn[1];
	assign seq_s  = syn[2];
	assign dly_s  = syn[6:3];
	assign mon_s  = syn[7];
	assign uv_s   = syn[13:8];
	assign oc_s   = syn[14];
	assign th_s   = syn[15];

	// every comparator goes through two flops before use
	sss_sync #(
		.W (16)
	) u_sync (
		.clk   (aclk),
		.rst_n (aresetn),
		.ce    (ce),
		.d     (raw_in),
		.q_r   (syn)
	);

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	reg        hifreq_r;
	reg        fault_r;
	reg        therm_r;
	reg        en_d_r;
	reg        seq_d_r;
	reg [8:0]  div_r;
	reg        tick_r;
	reg [15:0] ftmr_r;
	reg [15:0] oc_r;
	reg [15:0] rtmr_r;
	reg [7:0]  awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0]  wstrb_r;
	reg        aw_have_r;
	reg        w_have_r;

	wire       run;
	wire [5:0] ss_done;
	wire [5:0] en_nxt;
	wire       uv_hit;
	wire       uv_set;
	wire       oc_set;
	wire       fault_clr;
	wire       rst_hold;
	wire [8:0] div_last;

	// ----------------------------------------------------------------
	// start conditions and enables
	// ----------------------------------------------------------------
	// all four conditions together
	assign run = !lock_s && en_s && !fault_r && !therm_r;

	// step-down first, logic rail after its soft-start, channels on delays
	assign en_nxt[0]   = run;
	assign en_nxt[1]   = run && ss_done[0];
	assign en_nxt[5:2] = {4{run}} & dly_s;

	// enables and sequencing controls come straight from flops
	always @(posedge aclk) begin
		if (!aresetn) begin
			reg_en        <= 6'h00;
			seq_blk_en    <= 1'b0;
			dly_charge    <= 1'b0;
			dly_discharge <= 1'b1;
			rail_off      <= 1'b0;
		end else if (ce) begin
			reg_en        <= en_nxt;
			seq_blk_en    <= run;
			dly_charge    <= run && seq_s;
			dly_discharge <= !(run && seq_s);
			rail_off      <= therm_r || th_s;
		end
	end

	// ----------------------------------------------------------------
	// switching clock tick
	// ----------------------------------------------------------------
	assign div_last = hifreq_r ? `SSS_DIV_LAST_HI : `SSS_DIV_LAST_LO;

	// the tick stands in for one switching clock period
	always @(posedge aclk) begin
		if (!aresetn) begin
			div_r  <= 9'h000;
			tick_r <= 1'b0;
		end else if (ce) begin
			tick_r <= (div_r == div_last);
			if (div_r >= div_last)
				div_r <= 9'h000;
			else
				div_r <= div_r + 9'h001;
		end
	end

	// ----------------------------------------------------------------
	// soft-start ramps
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_ss
			// the last channel is the negative regulator
			sss_softstart #(
				.NEG ((gi == 5) ? 1 : 0)
			) u_ss (
				.clk     (aclk),
				.rst_n   (aresetn),
				.ce      (ce),
				.run     (reg_en[gi]),
				.tick    (tick_r),
				.hi_freq (hifreq_r),
				.code_r  (ref_code[gi*6 +: 6]),
				.done_r  (ss_done[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// fault timer and overcurrent filter
	// ----------------------------------------------------------------
	// only regulators past soft-start count as undervoltage
	assign uv_hit = |(uv_s & ss_done & reg_en);
	assign uv_set = uv_hit && (ftmr_r == FAULT_CYC - 16'h0001);
	assign oc_set = oc_s && (oc_r == OC_FILT_CYC - 16'h0001);

	// any break in the condition restarts the count
	always @(posedge aclk) begin
		if (!aresetn) begin
			ftmr_r <= 16'h0000;
			oc_r   <= 16'h0000;
		end else if (ce) begin
			if (uv_hit && !uv_set)
				ftmr_r <= ftmr_r + 16'h0001;
			else
				ftmr_r <= 16'h0000;
			if (oc_s && !oc_set)
				oc_r <= oc_r + 16'h0001;
			else
				oc_r <= 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// fault and thermal latches
	// ----------------------------------------------------------------
	assign fault_clr = lock_s || (en_s && !en_d_r) ||
	                   (seq_s && !seq_d_r);

	// a set in the clearing cycle wins over the clear
	always @(posedge aclk) begin
		if (!aresetn) begin
			fault_r <= 1'b0;
			therm_r <= 1'b0;
			en_d_r  <= 1'b0;
			seq_d_r <= 1'b0;
		end else if (ce) begin
			en_d_r  <= en_s;
			seq_d_r <= seq_s;
			if (uv_set || oc_set)
				fault_r <= 1'b1;
			else if (fault_clr)
				fault_r <= 1'b0;
			if (th_s)
				therm_r <= 1'b1;
			else if (lock_s)
				therm_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// reset output
	// ----------------------------------------------------------------
	// the pin level is never read back anywhere
	assign rst_hold = !mon_s || lock_s || !en_s || fault_r ||
	                  therm_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			rtmr_r       <= 16'h0000;
			rst_pin_o    <= 1'b0;
			rst_pin_oe_n <= 1'b0;
		end else if (ce) begin
			rst_pin_o <= 1'b0;
			if (rst_hold) begin
				rtmr_r       <= 16'h0000;
				rst_pin_oe_n <= 1'b0;
			end else if (rtmr_r == RST_CYC - 16'h0001) begin
				rst_pin_oe_n <= 1'b1;
			end else begin
				rtmr_r <= rtmr_r + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// bus slave, write side
	// ----------------------------------------------------------------
	// address and data are caught in either order, one write at a time
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready   <= 1'b0;
			wready    <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= `SSS_RESP_OKAY;
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h00000000;
			wstrb_r   <= 4'h0;
			hifreq_r  <= `SSS_CTRL_HIFREQ_RST;
		end else if (ce) begin
			awready <= !aw_have_r && !awready && !bvalid && awvalid;
			wready  <= !w_have_r && !wready && !bvalid && wvalid;
			if (awvalid && awready) begin
				aw_have_r <= 1'b1;
				awaddr_r  <= awaddr;
			end
			if (wvalid && wready) begin
				w_have_r <= 1'b1;
				wdata_r  <= wdata;
				wstrb_r  <= wstrb;
			end
			if (aw_have_r && w_have_r && !bvalid) begin
				aw_have_r <= 1'b0;
				w_have_r  <= 1'b0;
				bvalid    <= 1'b1;
				if (awaddr_r[7:2] == `SSS_ADDR_CTRL >> 2) begin
					bresp <= `SSS_RESP_OKAY;
					if (wstrb_r[0])
						hifreq_r <= wdata_r[`SSS_CTRL_HIFREQ];
				end else if (awaddr_r[7:2] == `SSS_ADDR_STATUS >> 2 ||
				             awaddr_r[7:2] == `SSS_ADDR_REF_LO >> 2 ||
				             awaddr_r[7:2] == `SSS_ADDR_REF_HI >> 2) begin
					bresp <= `SSS_RESP_OKAY;     // read-only, ignored
				end else begin
					bresp <= `SSS_RESP_SLVERR;
				end
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// bus slave, read side
	// ----------------------------------------------------------------
	// status shows latches, enables and soft-start progress
	always @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= `SSS_RESP_OKAY;
		end else if (ce) begin
			arready <= !arready && !rvalid && arvalid;
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rresp  <= `SSS_RESP_OKAY;
				case (araddr[7:2])
				`SSS_ADDR_CTRL >> 2:
					rdata <= {31'h00000000, hifreq_r};
				`SSS_ADDR_STATUS >> 2:
					rdata <= {16'h0000, rst_pin_oe_n, run, therm_r,
					          fault_r, ss_done, reg_en};
				`SSS_ADDR_REF_LO >> 2:
					rdata <= {14'h0000, ref_code[17:0]};
				`SSS_ADDR_REF_HI >> 2:
					rdata <= {14'h0000, ref_code[35:18]};
				default: begin
					rdata <= 32'h00000000;
					rresp <= `SSS_RESP_SLVERR;
				end
				endcase
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

endmodule

// *** logic/sss_consts.vh ***
// How it works
// - regulators run only with rail ok, enable high, fault and thermal clear
// - step-down starts first; logic rail soft-starts after step-down is done
// - sequence block enables with the step-down; channels two to five wait for their delays
// - sequence high and block enabled turns on every delay charge source
// - otherwise charge sources off and delay discharge switches closed
// - each channel two to five enables on its own delay comparator
// - every positive enable runs a 32-step soft-start from zero to full scale
// - negative regulator ramps from rail level down to final in 32 steps
// - soft-start lasts 1024 switching clocks low, 2048 high frequency
// - reset output low while monitor input is below trip level
// - reset also low in lockout, enable low or any fault latch set
// - reset released only after monitor stays good for full timeout
// - reset output state feeds no other logic, only the status register read-back
// - after soft-start, undervoltage on any output runs the fault timer
// - undervoltage lasting the whole timer sets fault latch, stops regulators
// - fault latch clears on power cycle or sequence or enable rising edge
// - thermal trip sets thermal latch at once, shuts off all incl rail
// - thermal latch clears only by power cycle, not by edges
// - overcurrent lasting the filter window sets fault latch and stops regulators
// - overcurrent pulses shorter than filter window never set the latch
// - rail lockout clears fault and thermal latches while it lasts
// - enable rising edge clears every fault except thermal
`ifndef SSS_CONSTS_VH
`define SSS_CONSTS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SSS_ADDR_CTRL     8'h00
`define SSS_ADDR_STATUS   8'h04
`define SSS_ADDR_REF_LO   8'h08
`define SSS_ADDR_REF_HI   8'h0c
`define SSS_CTRL_HIFREQ   0
`define SSS_CTRL_RESET    32'h00000000
`define SSS_CTRL_HIFREQ_RST 1'b0
`define SSS_RESP_OKAY     2'b00
`define SSS_RESP_SLVERR   2'b10

// ----------------------------------------------------------------
// soft-start
// ----------------------------------------------------------------
`define SSS_SS_STEPS      6'h20
`define SSS_SS_LAST_STEP  6'h1f
`define SSS_STEP_LAST_LO  6'h1f
`define SSS_STEP_LAST_HI  6'h3f

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSS_CLK_HZ        100000000
`define SSS_FSW_LO_HZ     250000
`define SSS_FSW_HI_HZ     500000
`define SSS_DIV_LO        (`SSS_CLK_HZ / `SSS_FSW_LO_HZ)
`define SSS_DIV_HI        (`SSS_CLK_HZ / `SSS_FSW_HI_HZ)
`define SSS_DIV_LAST_LO   9'h18f
`define SSS_DIV_LAST_HI   9'h0c7
`define SSS_CLK_NS        10
`define SSS_OC_FILT_NS    50000
`define SSS_OC_FILT_CYC   ((`SSS_OC_FILT_NS + `SSS_CLK_NS - 1) / `SSS_CLK_NS)
`define SSS_FAULT_CYC     20000
`define SSS_RST_CYC       20000

`endif

// *** logic/sss_sync.v ***
`timescale 1ns/1ps
module sss_sync #(
	parameter W = 1
) (
	input  wire         clk,   // system clock
	input  wire         rst_n, // synchronous reset, active low
	input  wire         ce,    // clock enable
	input  wire [W-1:0] d,     // asynchronous level
	output reg  [W-1:0] q_r    // synchronised level
);

	reg [W-1:0] meta_r;

	// ----------------------------------------------------------------
	// two-flop synchroniser
	// ----------------------------------------------------------------
	// first stage feeds only the second stage
	always @(posedge clk) begin
		if (!rst_n) begin
			meta_r <= {W{1'b0}};
			q_r    <= {W{1'b0}};
		end else if (ce) begin
			meta_r <= d;
			q_r    <= meta_r;
		end
	end

endmodule

// *** logic/sss_softstart.v ***
`timescale 1ns/1ps
`include "sss_consts.vh"
module sss_softstart #(
	parameter NEG = 0
) (
	input  wire       clk,     // system clock
	input  wire       rst_n,   // synchronous reset, active low
	input  wire       ce,      // clock enable
	input  wire       run,     // regulator enabled
	input  wire       tick,    // one switching clock
	input  wire       hi_freq, // high switching frequency selected
	output reg  [5:0] code_r,  // reference code, 32 is full scale
	output reg        done_r   // soft-start complete
);

	localparam [5:0] START = (NEG != 0) ? `SSS_SS_STEPS : 6'h00;

	reg  [5:0] sub_r;
	reg  [5:0] step_r;
	wire [5:0] sub_last;

	// one step is 1/32 of the total period
	assign sub_last = hi_freq ? `SSS_STEP_LAST_HI : `SSS_STEP_LAST_LO;

	// ----------------------------------------------------------------
	// reference ramp
	// ----------------------------------------------------------------
	// restarts from the beginning each time the regulator is enabled
	always @(posedge clk) begin
		if (!rst_n) begin
			sub_r  <= 6'h00;
			step_r <= 6'h00;
			code_r <= START;
			done_r <= 1'b0;
		end else if (ce) begin
			if (!run) begin
				sub_r  <= 6'h00;
				step_r <= 6'h00;
				code_r <= START;
				done_r <= 1'b0;
			end else if (tick && !done_r) begin
				if (sub_r == sub_last) begin
					sub_r  <= 6'h00;
					step_r <= step_r + 6'h01;
					if (NEG != 0)
						code_r <= code_r - 6'h01;
					else
						code_r <= code_r + 6'h01;
					if (step_r == `SSS_SS_LAST_STEP)
						done_r <= 1'b1;
				end else begin
					sub_r <= sub_r + 6'h01;
				end
			end
		end
	end

endmodule

// *** testbench/sss_top_props.sv ***
`timescale 1ns/1ps
module sss_props #(
	parameter [15:0] OC_FILT_CYC = 16'h0008,
	parameter [15:0] RST_CYC     = 16'h0014
) (
	input wire        aclk,          // clock
	input wire        aresetn,       // sync reset, active low
	input wire        rail_lockout,  // rail below lockout
	input wire        enable_cmp,    // enable above threshold
	input wire        seq_ctl,       // sequence control
	input wire [3:0]  dly_cross,     // delay comparators
	input wire        rst_mon_ok,    // monitor above trip
	input wire        oc_cmp,        // overcurrent
	input wire        therm_cmp,     // over-temperature
	input wire [5:0]  reg_en,        // regulator enables
	input wire [35:0] ref_code,      // reference codes
	input wire        dly_charge,    // charge sources on
	input wire        dly_discharge, // discharge closed
	input wire        seq_blk_en,    // sequencing block on
	input wire        rst_pin_o,     // reset pin level
	input wire        rst_pin_oe_n,  // reset pin enable
	input wire        rail_off       // rail shut down
);
	reg [15:0] mon_cnt_r;
	reg [15:0] oc_cnt_r;

	// run lengths of raw inputs; the sync delay only makes them longer
	always @(posedge aclk) begin
		if (!aresetn || !rst_mon_ok)
			mon_cnt_r <= 16'h0000;
		else if (mon_cnt_r != 16'hffff)
			mon_cnt_r <= mon_cnt_r + 16'h0001;
		if (!aresetn || !oc_cmp)
			oc_cnt_r <= 16'h0000;
		else if (oc_cnt_r != 16'hffff)
			oc_cnt_r <= oc_cnt_r + 16'h0001;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// six samples cover two sync stages and the output register
	sequence s_en_low; (!enable_cmp)[*6]; endsequence
	sequence s_locked; rail_lockout[*6]; endsequence
	sequence s_hot; therm_cmp[*6]; endsequence

	chk_gate_enable: assert property (s_en_low |-> reg_en == 6'h00 && !rst_pin_oe_n)
		else $error("regulator or reset released with enable low");
	chk_lock_off: assert property (s_locked |-> reg_en == 6'h00 && !rst_pin_oe_n)
		else $error("output active during lockout");
	chk_hot_off: assert property (s_hot |-> rail_off && reg_en == 6'h00)
		else $error("thermal trip did not shut down");
	chk_hot_hold: assert property ((!rail_lockout)[*8] ##0 rail_off |=> rail_off)
		else $error("thermal latch cleared without lockout");
	chk_charge_blk: assert property (dly_charge |-> seq_blk_en && !dly_discharge)
		else $error("charging with block off or switch closed");
	chk_seq_dis: assert property ((!seq_ctl)[*6] |-> dly_discharge && !dly_charge)
		else $error("delay inputs not discharged with sequence low");
	chk_blk_buck: assert property (seq_blk_en == reg_en[0])
		else $error("sequencing block not enabled with step-down");
	chk_chan_dly: assert property ((dly_cross == 4'h0)[*6] |-> reg_en[5:2] == 4'h0)
		else $error("channel on without its delay crossing");
	chk_chan_buck: assert property (reg_en[5:2] != 4'h0 |-> reg_en[0])
		else $error("channel on while step-down off");
	chk_logic_late: assert property ($rose(reg_en[1]) |-> reg_en[0])
		else $error("logic rail enabled without step-down");
	chk_rst_mon: assert property ((!rst_mon_ok)[*6] |-> !rst_pin_oe_n && !rst_pin_o)
		else $error("reset released with monitor low");
	chk_rst_time: assert property ($rose(rst_pin_oe_n) |-> mon_cnt_r >= RST_CYC)
		else $error("reset released before timeout");
	chk_oc_trip: assert property (oc_cnt_r == OC_FILT_CYC + 16'h0006 |-> reg_en == 6'h00 && !rail_off)
		else $error("overcurrent did not stop regulators");
	chk_ramp_zero: assert property ($rose(reg_en[0]) |-> ref_code[5:0] == 6'h00)
		else $error("positive ramp not starting at zero");
	chk_neg_top: assert property ($rose(reg_en[5]) |-> ref_code[35:30] == 6'h20)
		else $error("negative ramp not starting at rail level");
endmodule

bind sss_top sss_props #(.OC_FILT_CYC(OC_FILT_CYC), .RST_CYC(RST_CYC)) u_props (
	.aclk, .aresetn, .rail_lockout, .enable_cmp, .seq_ctl, .dly_cross,
	.rst_mon_ok, .oc_cmp, .therm_cmp, .reg_en, .ref_code, .dly_charge,
	.dly_discharge, .seq_blk_en, .rst_pin_o, .rst_pin_oe_n, .rail_off
);

// *** testbench/sss_partner.sv ***
`timescale 1ns/1ps
module sss_partner (
	input  wire       aclk,          // clock
	input  wire       dly_charge,    // charge sources on
	input  wire       dly_discharge, // discharge switches closed
	input  wire [5:0] reg_en,        // regulator enables
	input  wire       mon_low,       // pull monitored output down
	output reg  [3:0] dly_cross,     // delay comparators
	output wire [5:0] uv_cmp,        // outputs below 90 percent
	output wire       rst_mon_ok     // monitored output good
);
	reg [7:0] cap_r [0:3];
	integer   j;
	integer   k;

	initial for (j = 0; j < 4; j = j + 1) cap_r[j] = 8'h00;

	// capacitors ramp a step a cycle; the switch empties them at once
	always @(posedge aclk) begin
		for (j = 0; j < 4; j = j + 1) begin
			if (dly_discharge)
				cap_r[j] <= 8'h00;
			else if (dly_charge && cap_r[j] != 8'hff)
				cap_r[j] <= cap_r[j] + 8'h01;
		end
	end

	// staggered capacitors so channels come up in order
	always @* begin
		for (k = 0; k < 4; k = k + 1)
			dly_cross[k] = cap_r[k] > 8'h10 * (k + 1);
	end

	// an output sits low until its regulator runs; monitor on step-down
	assign uv_cmp     = ~reg_en;
	assign rst_mon_ok = reg_en[0] && !mon_low;
endmodule

// *** testbench/tb_sss_top.sv ***
`timescale 1ns/1ps
`include "sss_consts.vh"
module tb_sss_top;
	reg         aclk         = 1'b0;
	reg         aresetn      = 1'b0;
	reg  [7:0]  awaddr       = 8'h00;
	reg         awvalid      = 1'b0;
	reg  [31:0] wdata        = 32'h0;
	reg  [3:0]  wstrb        = 4'h0;
	reg         wvalid       = 1'b0;
	reg         bready       = 1'b0;
	reg  [7:0]  araddr       = 8'h00;
	reg         arvalid      = 1'b0;
	reg         rready       = 1'b0;
	reg         rail_lockout = 1'b0;
	reg         enable_cmp   = 1'b0;
	reg         seq_ctl      = 1'b0;
	reg         oc_cmp       = 1'b0;
	reg         therm_cmp    = 1'b0;
	reg         mon_low      = 1'b0;
	reg         ce           = 1'b1;
	wire [1:0]  bresp, rresp;
	wire        awready, wready, bvalid, arready, rvalid, rst_mon_ok;
	wire        dly_charge, dly_discharge, seq_blk_en, rst_pin_o;
	wire        rst_pin_oe_n, rail_off;
	wire [31:0] rdata;
	wire [3:0]  dly_cross;
	wire [5:0]  uv_cmp, reg_en;
	wire [35:0] ref_code;
	integer     fails = 0, n_checks = 0, i, n, m, hf;

	sss_top #(.OC_FILT_CYC(16'h0008), .FAULT_CYC(16'h0014),
		.RST_CYC(16'h0014)) dut (
		.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.rail_lockout, .enable_cmp, .seq_ctl, .dly_cross, .rst_mon_ok,
		.uv_cmp, .oc_cmp, .therm_cmp, .reg_en, .ref_code, .dly_charge,
		.dly_discharge, .seq_blk_en, .rst_pin_o, .rst_pin_oe_n, .rail_off);

	sss_partner far_side (.aclk, .dly_charge, .dly_discharge, .reg_en,
		.mon_low, .dly_cross, .uv_cmp, .rst_mon_ok);

	always #5 aclk = ~aclk;

	// step length in system clocks; both frequencies meet at one length
	function integer step_cyc(input h);
		step_cyc = h ? 64 * 200 : 32 * 400;
	endfunction

	// status word with all regulators off
	function [31:0] exp_stat(input flt, input th);
		exp_stat = {18'h0, th, flt, 12'h000};
	endfunction

	task chk(input [63:0] seen, input [63:0] exp, input string what);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("MISMATCH %s exp %0h seen %0h", what, exp, seen);
			end
		end
	endtask

	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", n_checks, fails);
			if (fails == 0 && n_checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask

	task tk(input integer c);
		repeat (c) @(posedge aclk);
	endtask

	// bready rides along; the answer edge is where bvalid is seen
	task wr(input [7:0] a, input [31:0] v, input [1:0] er);
		reg [1:0] r;
		integer   k;
		begin
			r = ~er;
			awaddr <= a;
			wdata <= v;
			wstrb <= 4'hf;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			k = 0;
			while (k == 0) begin
				@(posedge aclk);
				if (awvalid && awready)
					awvalid <= 1'b0;
				if (wvalid && wready)
					wvalid <= 1'b0;
				if (bvalid) begin
					r = bresp;
					k = 1;
				end
			end
			bready <= 1'b0;
			tk(1);
			chk(r, er, "bresp");
		end
	endtask

	task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
		reg [31:0] d;
		reg [1:0]  r;
		integer    k;
		begin
			d = ~ed;
			r = ~er;
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			k = 0;
			while (k == 0) begin
				@(posedge aclk);
				if (arvalid && arready)
					arvalid <= 1'b0;
				if (rvalid) begin
					d = rdata;
					r = rresp;
					k = 1;
				end
			end
			rready <= 1'b0;
			tk(1);
			chk(d, ed, "rdata");
			chk(r, er, "rresp");
		end
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		n = $urandom(32'h0dd6);
		tk(6);
		aresetn <= 1'b1;
		tk(1);
		chk({reg_en, dly_discharge, rst_pin_oe_n}, 8'h02, "reset");
		rd(`SSS_ADDR_CTRL, `SSS_CTRL_RESET, `SSS_RESP_OKAY);
		m = 4 + $urandom % 60;
		rd({m[5:0], 2'b00}, 32'h0, `SSS_RESP_SLVERR);
		wr(`SSS_ADDR_STATUS, $urandom, `SSS_RESP_OKAY);
		rd(`SSS_ADDR_STATUS, 32'h0, `SSS_RESP_OKAY);
		wr(`SSS_ADDR_CTRL, 32'h1, `SSS_RESP_OKAY);
		rd(`SSS_ADDR_CTRL, 32'h1, `SSS_RESP_OKAY);
		seq_ctl <= 1'b1;
		enable_cmp <= 1'b1;
		tk(6);
		chk(reg_en[1:0], 2'b01, "buck_first");
		chk({seq_blk_en, dly_charge, dly_discharge}, 3'b110, "seq");
		// each channel follows its own capacitor
		for (i = 2; i < 6; i = i + 1) begin
			for (n = 0; n < 200 && !reg_en[i]; n = n + 1)
				tk(1);
			chk(reg_en >> i, 6'h01, "chan_order");
		end
		chk(rst_pin_oe_n, 1'b1, "rst_release");
		// a dip of random length must restart the whole timeout
		mon_low <= 1'b1;
		tk(1 + $urandom % 3);
		mon_low <= 1'b0;
		tk(4);
		chk(rst_pin_oe_n, 1'b0, "rst_dip");
		tk(12);
		chk(rst_pin_oe_n, 1'b0, "rst_wait");
		tk(12);
		chk(rst_pin_oe_n, 1'b1, "rst_again");
		// one ramp step measured between two code changes, per frequency
		for (hf = 1; hf >= 0; hf = hf - 1) begin
			enable_cmp <= 1'b0;
			wr(`SSS_ADDR_CTRL, hf, `SSS_RESP_OKAY);
			tk(8);
			chk({reg_en, rst_pin_oe_n}, 7'h00, "en_low");
			enable_cmp <= 1'b1;
			for (n = 0; n < 14000 && ref_code[5:0] != 6'h01; n = n + 1)
				tk(1);
			for (n = 0; n < 14000 && ref_code[5:0] != 6'h02; n = n + 1)
				tk(1);
			chk(n, step_cyc(hf[0]), "step_len");
			chk(ref_code[11:6], 6'h00, "logic_wait");
		end
		oc_cmp <= 1'b1;
		tk(1 + $urandom % 5);
		oc_cmp <= 1'b0;
		tk(8);
		chk(reg_en[0], 1'b1, "oc_short");
		// trip, then clear by a sequence edge and by an enable edge
		for (i = 0; i < 2; i = i + 1) begin
			oc_cmp <= 1'b1;
			tk(14);
			oc_cmp <= 1'b0;
			chk({reg_en, rail_off, rst_pin_oe_n}, 8'h00, "oc_trip");
			rd(`SSS_ADDR_STATUS, exp_stat(1'b1, 1'b0), `SSS_RESP_OKAY);
			if (i == 1)
				enable_cmp <= 1'b0;
			else
				seq_ctl <= 1'b0;
			tk(8);
			chk(dly_discharge, 1'b1, "dly_dis");
			enable_cmp <= 1'b1;
			seq_ctl <= 1'b1;
			tk(8);
			chk(reg_en[0], 1'b1, "flt_clear");
		end
		therm_cmp <= 1'b1;
		tk(6);
		therm_cmp <= 1'b0;
		tk(4);
		chk({rail_off, reg_en}, 7'h40, "therm");
		enable_cmp <= 1'b0;
		seq_ctl <= 1'b0;
		tk(8);
		enable_cmp <= 1'b1;
		seq_ctl <= 1'b1;
		tk(8);
		rd(`SSS_ADDR_STATUS, exp_stat(1'b0, 1'b1), `SSS_RESP_OKAY);
		rail_lockout <= 1'b1;
		tk(8);
		chk(rst_pin_oe_n, 1'b0, "lock_rst");
		rail_lockout <= 1'b0;
		tk(8);
		chk({rail_off, reg_en[0]}, 2'b01, "lock_clr");
		// a frozen block must not count an overcurrent seen while ce is low
		ce <= 1'b0;
		oc_cmp <= 1'b1;
		tk(10);
		oc_cmp <= 1'b0;
		ce <= 1'b1;
		tk(8);
		chk(reg_en[0], 1'b1, "ce_freeze");
		print_verdict;
	end

	// the run needs about 52000 cycles
	initial begin
		#1000000;
		fails = fails + 1;
		print_verdict;
	end
endmodule
